// file: src/adc_window_consts.svh
`ifndef ADC_WINDOW_CONSTS_SVH
`define ADC_WINDOW_CONSTS_SVH

// Byte-wide register addresses
`define CTL_ADDR 8'he8
`define GTL_ADDR 8'hc3
`define GTH_ADDR 8'hc4
`define LTL_ADDR 8'hc5
`define LTH_ADDR 8'hc6
`define RESL_ADDR 8'hbd
`define RESH_ADDR 8'hbe

// Control register bit positions
`define CTL_ENABLE_BIT 7
`define CTL_TRACK_BIT 6
`define CTL_DONE_BIT 5
`define CTL_BUSY_BIT 4
`define CTL_WIN_BIT 3
`define CTL_SEL_MSB 2
`define CTL_SEL_LSB 0

// Reset values
`define GT_RESET 8'hff
`define LT_RESET 8'h00
`define CTL_RESET 8'h00
`define RES_RESET 8'h00

// Extra tracking, in converter clocks
`define TRACK_CLOCKS 2'd3

`endif

// file: src/adc_window_pkg.sv
package adc_window_pkg;

  // Start-of-conversion source codes
  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'h0,
    SRC_TIMER0 = 3'h1,
    SRC_TIMER2 = 3'h2,
    SRC_TIMER1 = 3'h3,
    SRC_EXTERNAL = 3'h4,
    SRC_TIMER3 = 3'h5,
    SRC_TIMER4 = 3'h6,
    SRC_NONE = 3'h7
  } start_src_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } conv_state_t;

endpackage : adc_window_pkg

// file: src/window_compare.sv
`timescale 1ns/10ps
`include "adc_window_consts.svh"

// Pure compare of one result against both limits
module window_compare
  import adc_window_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic [WIDTH-1:0] result,
  input wire logic [WIDTH-1:0] gt_limit,
  input wire logic [WIDTH-1:0] lt_limit,
  output logic match
);

  // Limit order alone picks inside or outside; no mode bit exists
  always_comb
  begin
    if (lt_limit > gt_limit)
    begin
      // Inside window, both bounds exclusive
      match = (result > gt_limit) && (result < lt_limit); // [RULE_13] [RULE_11]
    end
    else
    begin
      // Outside window, both bounds exclusive
      match = (result < lt_limit) || (result > gt_limit); // [RULE_14] [RULE_11]
    end
  end

endmodule : window_compare

// file: src/adc_start_window.sv
// Function
// [RULE_01] Window flag reads one after any match
// [RULE_02] Select 000: start on busy-bit write
// [RULE_03] Select 001: timer 0 overflow starts
// [RULE_04] Select 010: timer 2 overflow starts
// [RULE_05] Select 011: timer 1 overflow starts
// [RULE_06] Select 100: external rising edge starts
// [RULE_07] Select 101/110: timers 3/4 start
// [RULE_08] Compare results automatically, signal on match
// [RULE_09] Flag usable as interrupt or polled
// [RULE_10] Two 16-bit limits, byte-split registers
// [RULE_11] Limit order chooses inside or outside
// [RULE_12] Greater-than high byte: RW, resets ones
// [RULE_13] Inside window when less-than exceeds greater-than
// [RULE_14] Outside window otherwise, bounds exclusive
// [RULE_15] Delayed track adds three clocks, not external
// [RULE_16] Compare per new result; flag sticky
`timescale 1ns/10ps
`include "adc_window_consts.svh"

module adc_start_window
  import adc_window_pkg::*;
#(
  parameter int RES_WIDTH = 16
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic [4:0] timer_overflow,
  input wire logic external_convert_start,
  input wire logic sar_tick,
  input wire logic result_valid,
  input wire logic [RES_WIDTH-1:0] result_data,
  output logic convert_start,
  output logic conversion_busy,
  output logic window_match_flag
);

  // Software-visible registers and internal state
  logic [7:0] gth_reg; // Greater-than high byte
  logic [7:0] gtl_reg; // Greater-than low byte
  logic [7:0] lth_reg; // Less-than high byte
  logic [7:0] ltl_reg; // Less-than low byte
  logic [RES_WIDTH-1:0] result_reg; // Latched conversion word
  logic enable_reg; // Stored only, no effect here
  logic track_mode_reg; // Delayed track select
  logic done_reg; // Conversion complete flag
  logic [2:0] sel_reg; // Start source select
  logic ext_prev_reg; // Previous external pin level
  logic [1:0] track_cnt_reg; // Converter clocks tracked so far
  logic compare_pending_reg; // New result awaiting compare
  conv_state_t state_reg;
  logic match;
  logic ctl_wr;
  logic start_event;
  logic [15:0] gt_limit;
  logic [15:0] lt_limit;

  assign ctl_wr = sfr_wr && (sfr_addr == `CTL_ADDR);
  assign gt_limit = {gth_reg, gtl_reg}; // [RULE_10]
  assign lt_limit = {lth_reg, ltl_reg}; // [RULE_10]

  // Start source decode; unused code 111 never starts
  always_comb
  begin
    unique case (start_src_t'(sel_reg))
      SRC_SOFTWARE: start_event = ctl_wr && sfr_wdata[`CTL_BUSY_BIT]; // [RULE_02]
      SRC_TIMER0: start_event = timer_overflow[0]; // [RULE_03]
      SRC_TIMER2: start_event = timer_overflow[2]; // [RULE_04]
      SRC_TIMER1: start_event = timer_overflow[1]; // [RULE_05]
      SRC_EXTERNAL: start_event = external_convert_start && !ext_prev_reg; // [RULE_06]
      SRC_TIMER3: start_event = timer_overflow[3]; // [RULE_07]
      SRC_TIMER4: start_event = timer_overflow[4]; // [RULE_07]
      SRC_NONE: start_event = 1'b0;
    endcase
  end

  // Pin history for rising-edge detection
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      ext_prev_reg <= 1'b0;
    else if (ce)
      ext_prev_reg <= external_convert_start;
  end

  // Limit registers, byte writes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      gth_reg <= `GT_RESET; // [RULE_12]
      gtl_reg <= `GT_RESET;
      lth_reg <= `LT_RESET;
      ltl_reg <= `LT_RESET;
    end
    else if (ce && sfr_wr)
    begin
      if (sfr_addr == `GTH_ADDR)
        gth_reg <= sfr_wdata; // [RULE_12]
      if (sfr_addr == `GTL_ADDR)
        gtl_reg <= sfr_wdata;
      if (sfr_addr == `LTH_ADDR)
        lth_reg <= sfr_wdata;
      if (sfr_addr == `LTL_ADDR)
        ltl_reg <= sfr_wdata;
    end
  end

  // Plain control fields
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      enable_reg <= 1'b0;
      track_mode_reg <= 1'b0;
      sel_reg <= 3'(`CTL_RESET);
    end
    else if (ce && ctl_wr)
    begin
      enable_reg <= sfr_wdata[`CTL_ENABLE_BIT];
      track_mode_reg <= sfr_wdata[`CTL_TRACK_BIT];
      sel_reg <= sfr_wdata[`CTL_SEL_MSB:`CTL_SEL_LSB];
    end
  end

  // Sequencer: starts while busy are dropped, a conversion is never cut short
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      track_cnt_reg <= 2'd0;
      convert_start <= 1'b0;
      conversion_busy <= 1'b0;
    end
    else if (ce)
    begin
      convert_start <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (start_event)
          begin
            conversion_busy <= 1'b1;
            track_cnt_reg <= 2'd0;
            // External pin start skips the extra tracking
            if (track_mode_reg && (sel_reg != SRC_EXTERNAL))
              state_reg <= ST_TRACK; // [RULE_15]
            else
            begin
              state_reg <= ST_CONVERT; // [RULE_15]
              convert_start <= 1'b1;
            end
          end
        end
        ST_TRACK:
        begin
          // Count converter clocks, then launch
          if (sar_tick)
          begin
            if (track_cnt_reg == `TRACK_CLOCKS - 2'd1)
            begin
              state_reg <= ST_CONVERT; // [RULE_15]
              convert_start <= 1'b1;
            end
            track_cnt_reg <= track_cnt_reg + 2'd1;
          end
        end
        ST_CONVERT:
        begin
          // Converter reports end of conversion with the result
          if (result_valid)
          begin
            state_reg <= ST_IDLE;
            conversion_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // Result capture; compare runs the cycle after the write
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      result_reg <= '0;
      compare_pending_reg <= 1'b0;
    end
    else if (ce)
    begin
      compare_pending_reg <= result_valid; // [RULE_16]
      if (result_valid)
        result_reg <= result_data;
    end
  end

  // Compare against the stored result, not the raw bus
  window_compare #(
    .WIDTH(16)
  ) u_compare (
    .result(16'(result_reg)),
    .gt_limit(gt_limit),
    .lt_limit(lt_limit),
    .match(match)
  );

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      window_match_flag <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (compare_pending_reg && match)
        window_match_flag <= 1'b1; // [RULE_01] [RULE_08] [RULE_09]
      else if (ctl_wr && !sfr_wdata[`CTL_WIN_BIT])
        window_match_flag <= 1'b0; // [RULE_16]
      if (result_valid)
        done_reg <= 1'b1;
      else if (ctl_wr && !sfr_wdata[`CTL_DONE_BIT])
        done_reg <= 1'b0;
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      sfr_rdata <= 8'h00;
    else if (ce && sfr_rd)
    begin
      unique case (sfr_addr)
        `CTL_ADDR: sfr_rdata <= {enable_reg, track_mode_reg, done_reg, conversion_busy,
                                 window_match_flag, sel_reg}; // [RULE_09]
        `GTH_ADDR: sfr_rdata <= gth_reg; // [RULE_12]
        `GTL_ADDR: sfr_rdata <= gtl_reg;
        `LTH_ADDR: sfr_rdata <= lth_reg;
        `LTL_ADDR: sfr_rdata <= ltl_reg;
        `RESH_ADDR: sfr_rdata <= result_reg[15:8];
        `RESL_ADDR: sfr_rdata <= result_reg[7:0];
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  flag_set_match_a: assert property (ce && compare_pending_reg && match |=> window_match_flag) // [RULE_01]
    else $error("window flag not set after match");
  flag_sticky_a: assert property (ce && window_match_flag && !ctl_wr |=> window_match_flag) // [RULE_16]
    else $error("window flag dropped without clear");
  flag_clean_a: assert property (ce && !window_match_flag && !(compare_pending_reg && match)
    |=> !window_match_flag) // [RULE_01]
    else $error("window flag set without match");
  sw_start_a: assert property (ce && state_reg == ST_IDLE && sel_reg == 3'h0 && ctl_wr
    && sfr_wdata[`CTL_BUSY_BIT] |=> conversion_busy) // [RULE_02]
    else $error("software start ignored");
  timer0_start_a: assert property (ce && state_reg == ST_IDLE && sel_reg == 3'h1 && timer_overflow[0]
    |=> conversion_busy) // [RULE_03]
    else $error("timer 0 start ignored");
  timer2_start_a: assert property (ce && state_reg == ST_IDLE && sel_reg == 3'h2 && timer_overflow[2]
    |=> conversion_busy) // [RULE_04]
    else $error("timer 2 start ignored");
  timer1_start_a: assert property (ce && state_reg == ST_IDLE && sel_reg == 3'h3 && timer_overflow[1]
    |=> conversion_busy) // [RULE_05]
    else $error("timer 1 start ignored");
  ext_edge_a: assert property (ce && state_reg == ST_IDLE && sel_reg == 3'h4 && external_convert_start
    && !ext_prev_reg |=> convert_start) // [RULE_06] [RULE_15]
    else $error("external edge start missing or delayed");
  timer34_start_a: assert property (ce && state_reg == ST_IDLE && ((sel_reg == 3'h5 && timer_overflow[3])
    || (sel_reg == 3'h6 && timer_overflow[4])) |=> conversion_busy) // [RULE_07]
    else $error("timer 3 or 4 start ignored");
  track_delay_a: assert property (ce && state_reg == ST_IDLE && start_event && track_mode_reg
    && sel_reg != 3'h4 |=> state_reg == ST_TRACK && !convert_start) // [RULE_15]
    else $error("delayed tracking skipped");
  gth_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0) !rst_b |=> gth_reg == 8'hff) // [RULE_12]
    else $error("greater-than high byte bad reset");

  cover_inside_c: cover property (compare_pending_reg && match && lt_limit > gt_limit);
  cover_outside_c: cover property (compare_pending_reg && match && lt_limit <= gt_limit);
  cover_track_c: cover property (state_reg == ST_TRACK ##[1:40] convert_start);
  cover_ext_c: cover property (sel_reg == 3'h4 && convert_start);

endmodule : adc_start_window

// file: bench/adc_start_select_window_detect_tb.sv
`timescale 1ns/10ps
`include "adc_window_consts.svh"

module adc_start_select_window_detect_tb;
  import adc_window_pkg::*;

  // Start-source rows: control select, event inputs, expected start
  typedef struct packed {
    logic [2:0] sel;
    logic [4:0] tmr;
    logic ext;
    logic sw;
    logic exp;
  } start_row_t;

  // Window rows: limits, result, expected flag
  typedef struct packed {
    logic [15:0] gt;
    logic [15:0] lt;
    logic [15:0] res;
    logic exp;
  } win_row_t;

  logic clk_sys = 1'b0; // 125 MHz system clock
  logic rst_b = 1'b0; // Active-low synchronous reset
  logic ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic [4:0] timer_overflow = 5'h00;
  logic external_convert_start = 1'b0;
  logic sar_tick = 1'b0;
  logic result_valid = 1'b0;
  logic [15:0] result_data = 16'h0000;
  logic convert_start;
  logic conversion_busy;
  logic window_match_flag;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] d; // Last read byte
  logic seen; // Start pulse seen in a span

  start_row_t srow [10] = '{
    '{3'h0, 5'h1f, 1'b0, 1'b0, 1'b0}, '{3'h0, 5'h00, 1'b0, 1'b1, 1'b1},
    '{3'h1, 5'h01, 1'b0, 1'b0, 1'b1}, '{3'h1, 5'h1e, 1'b1, 1'b0, 1'b0},
    '{3'h2, 5'h04, 1'b0, 1'b0, 1'b1}, '{3'h3, 5'h02, 1'b0, 1'b0, 1'b1},
    '{3'h4, 5'h00, 1'b1, 1'b0, 1'b1}, '{3'h5, 5'h08, 1'b0, 1'b0, 1'b1},
    '{3'h6, 5'h10, 1'b0, 1'b0, 1'b1}, '{3'h7, 5'h1f, 1'b1, 1'b1, 1'b0}};

  // Bounds are exclusive, so each edge value sits beside its neighbour
  win_row_t wrow [9] = '{
    '{16'h0040, 16'h0080, 16'h0041, 1'b1}, '{16'h0040, 16'h0080, 16'h0040, 1'b0},
    '{16'h0040, 16'h0080, 16'h007f, 1'b1}, '{16'h0040, 16'h0080, 16'h0080, 1'b0},
    '{16'h0080, 16'h0040, 16'h003f, 1'b1}, '{16'h0080, 16'h0040, 16'h0040, 1'b0},
    '{16'h0080, 16'h0040, 16'h0081, 1'b1}, '{16'h0080, 16'h0040, 16'h0060, 1'b0},
    '{16'h0080, 16'h0040, 16'h0080, 1'b0}};

  adc_start_window u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer_overflow(timer_overflow),
    .external_convert_start(external_convert_start), .sar_tick(sar_tick),
    .result_valid(result_valid), .result_data(result_data), .convert_start(convert_start),
    .conversion_busy(conversion_busy), .window_match_flag(window_match_flag)
  );

  // Free-running clock, 8 ns period
  always #4 clk_sys = ~clk_sys;

  // Compare of one byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t byte got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Compare of one flag
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // Register write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : wr

  // Register read, data taken after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask : rd

  // Both limits, byte by byte
  task automatic set_lim(input logic [15:0] gt, input logic [15:0] lt);
    wr(`GTH_ADDR, gt[15:8]);
    wr(`GTL_ADDR, gt[7:0]);
    wr(`LTH_ADDR, lt[15:8]);
    wr(`LTL_ADDR, lt[7:0]);
  endtask : set_lim

  // Fire start events for one edge, then look one cycle on
  task automatic fire(input logic [4:0] t, input logic x, input logic [7:0] sw_val, input logic sw);
    @(posedge clk_sys);
    timer_overflow <= t;
    external_convert_start <= x;
    if (sw)
    begin
      sfr_addr <= `CTL_ADDR;
      sfr_wdata <= sw_val;
      sfr_wr <= 1'b1;
    end
    @(posedge clk_sys);
    timer_overflow <= 5'h00;
    external_convert_start <= 1'b0;
    sfr_wr <= 1'b0;
    #1;
  endtask : fire

  // End-of-conversion pulse, then time for latch and compare
  task automatic conv(input logic [15:0] v);
    @(posedge clk_sys);
    result_valid <= 1'b1;
    result_data <= v;
    @(posedge clk_sys);
    result_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : conv

  // One converter clock enable
  task automatic tick();
    @(posedge clk_sys);
    sar_tick <= 1'b1;
    @(posedge clk_sys);
    sar_tick <= 1'b0;
    #1;
  endtask : tick

  // Verdict and end of run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values, unmapped place reads zero
    rd(`GTH_ADDR, d); chk8(d, 8'hff);
    rd(`GTL_ADDR, d); chk8(d, 8'hff);
    rd(`LTH_ADDR, d); chk8(d, 8'h00);
    rd(`LTL_ADDR, d); chk8(d, 8'h00);
    rd(`CTL_ADDR, d); chk8(d, 8'h00);
    rd(8'h00, d); chk8(d, 8'h00);
    $display("Test reset done");
    // Start sources, allowed and refused
    foreach (srow[i])
    begin
      wr(`CTL_ADDR, {5'h00, srow[i].sel});
      fire(srow[i].tmr, srow[i].ext, {4'h1, 1'b0, srow[i].sel}, srow[i].sw);
      chk1(convert_start, srow[i].exp);
      chk1(conversion_busy, srow[i].exp);
      if (srow[i].exp)
        conv(16'h0123);
      chk1(conversion_busy, 1'b0);
    end
    // Last latched word was 0x0123; its high byte must read back
    rd(`RESH_ADDR, d); chk8(d, 8'h01);
    $display("Test start sources done");
    // Window inside and outside, polled and at the port
    foreach (wrow[i])
    begin
      set_lim(wrow[i].gt, wrow[i].lt);
      wr(`CTL_ADDR, 8'h01);
      fire(5'h01, 1'b0, 8'h00, 1'b0);
      conv(wrow[i].res);
      chk1(window_match_flag, wrow[i].exp);
      rd(`CTL_ADDR, d); chk1(d[3], wrow[i].exp);
      rd(`RESL_ADDR, d); chk8(d, wrow[i].res[7:0]);
    end
    $display("Test window rows done");
    // Sticky flag over a later miss, cleared by writing zero
    set_lim(16'h0040, 16'h0080);
    wr(`CTL_ADDR, 8'h01);
    fire(5'h01, 1'b0, 8'h00, 1'b0);
    conv(16'h0050);
    fire(5'h01, 1'b0, 8'h00, 1'b0);
    conv(16'h0010);
    chk1(window_match_flag, 1'b1);
    wr(`CTL_ADDR, 8'h01);
    #1 chk1(window_match_flag, 1'b0);
    $display("Test sticky flag done");
    // Start while busy is dropped
    fire(5'h01, 1'b0, 8'h00, 1'b0);
    fire(5'h01, 1'b0, 8'h00, 1'b0);
    chk1(convert_start, 1'b0);
    conv(16'h0000);
    // Delayed track: three ticks before the start pulse
    wr(`CTL_ADDR, 8'h41);
    fire(5'h01, 1'b0, 8'h00, 1'b0);
    chk1(convert_start, 1'b0);
    chk1(conversion_busy, 1'b1);
    tick();
    tick();
    chk1(convert_start, 1'b0);
    tick();
    seen = convert_start;
    @(posedge clk_sys);
    #1 seen = seen | convert_start;
    chk1(seen, 1'b1);
    conv(16'h0000);
    // External pin ignores delayed track
    wr(`CTL_ADDR, 8'h44);
    fire(5'h00, 1'b1, 8'h00, 1'b0);
    chk1(convert_start, 1'b1);
    conv(16'h0000);
    $display("Test track mode done");
    // Register access, and writes frozen with clock enable low
    wr(`GTH_ADDR, 8'h12);
    rd(`GTH_ADDR, d); chk8(d, 8'h12);
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(`GTH_ADDR, 8'h55);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(`GTH_ADDR, d); chk8(d, 8'h12);
    $display("Test register access done");
    // Mid-run reset with a conversion pending and clock enable low
    fire(5'h00, 1'b1, 8'h00, 1'b0);
    chk1(conversion_busy, 1'b1);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    ce <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    ce <= 1'b1;
    #1 chk1(conversion_busy, 1'b0);
    chk1(window_match_flag, 1'b0);
    rd(`GTH_ADDR, d); chk8(d, 8'hff);
    rd(`CTL_ADDR, d); chk8(d, 8'h00);
    $display("Test mid-run reset done");
    give_verdict();
  end

endmodule : adc_start_select_window_detect_tb
